//--- ref_pulse_align_pkg.sv
// Constants, register map and field layouts for the reference pulse aligner
// Contract
// RULE1: With align_every_pulse set, every pulse realigns the dividers.
// RULE2: align_next_pulse_once uses only the next pulse, then self-clears.
// RULE3: align_on_second_pulse moves the one-shot to pulse two, stays set.
// RULE4: nco_reset_every_pulse with every-pulse mode resets NCO per align.
// RULE5: nco_reset_next_pulse_once resets NCO on the one-shot align, clears.
// RULE6: nco_reset_on_second_pulse also resets NCO on pulse two, stays set.
// RULE7: A 5-bit offset in frames delays the multiframe edge; more is later.
// RULE8: No realign for a pulse at most 2*early_tolerance cycles early.
// RULE9: No realign for a pulse at most 2*late_tolerance cycles late.
// RULE10: serializer_polarity_select inverts the serializer data when one.
// RULE11: Sampling select zero samples on the synth tick, one at half rate.
// RULE12: With the receiver powered down no reference pulse is detected.
// RULE13: Writing the one-shot bit set restarts the second-pulse count.
// RULE14: The generator sends pulses at a multiple of the multiframe period; ref_pulse_gen sends one pulse per arm at any grid slot.
package ref_pulse_align_pkg;

	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int REG_W = 8;
	localparam int SER_W = 10;

	// Register indices; byte address is four times the index
	localparam logic [9:0] IDX_ALIGN_CTRL = 10'h1e8;
	localparam logic [9:0] IDX_MF_OFFSET = 10'h1e9;
	localparam logic [9:0] IDX_WINDOW = 10'h1ea;
	localparam logic [9:0] IDX_SER_POL = 10'h1eb;
	localparam logic [9:0] IDX_RX_CTRL = 10'h1f0;
	localparam logic [9:0] IDX_STATUS = 10'h1f1;

	localparam logic [ADDR_W-1:0] ADDR_ALIGN_CTRL = {IDX_ALIGN_CTRL, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_MF_OFFSET = {IDX_MF_OFFSET, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_WINDOW = {IDX_WINDOW, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_SER_POL = {IDX_SER_POL, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_RX_CTRL = {IDX_RX_CTRL, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_STATUS = {IDX_STATUS, 2'b00};

	localparam logic [REG_W-1:0] RST_ALIGN_CTRL = 8'h00;
	localparam logic [REG_W-1:0] RST_MF_OFFSET = 8'h00;
	localparam logic [REG_W-1:0] RST_WINDOW = 8'h00;
	localparam logic [REG_W-1:0] RST_SER_POL = 8'h1c;
	localparam logic [REG_W-1:0] RST_RX_CTRL = 8'h01;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// Divider model: 4 cycles per frame, 32 frames per multiframe
	localparam int FRAME_BITS = 2;
	localparam int MF_FRAME_BITS = 5;
	localparam int PHASE_W = FRAME_BITS + MF_FRAME_BITS;
	localparam logic [PHASE_W-1:0] PHASE_ZERO = 7'h00;
	localparam logic [PHASE_W-1:0] PHASE_AFTER_ALIGN = 7'h01;
	localparam logic [FRAME_BITS-1:0] FRAME_START = 2'h0;
	localparam int TOL_W = 4;

	typedef struct packed {
		logic rsvd7;
		logic nco_reset_on_second_pulse;
		logic nco_reset_next_pulse_once;
		logic nco_reset_every_pulse;
		logic rsvd3;
		logic align_on_second_pulse;
		logic align_next_pulse_once;
		logic align_every_pulse;
	} align_ctrl_type;

	typedef struct packed {
		logic [2:0] rsvd;
		logic [MF_FRAME_BITS-1:0] frame_offset;
	} mf_offset_type;

	typedef struct packed {
		logic [TOL_W-1:0] early_tolerance;
		logic [TOL_W-1:0] late_tolerance;
	} window_type;

	typedef struct packed {
		logic serializer_polarity_select;
		logic [6:0] rsvd;
	} ser_pol_type;

	typedef struct packed {
		logic [3:0] rsvd_hi;
		logic ref_pulse_receiver_powerdown;
		logic [1:0] rsvd_mid;
		logic ref_pulse_sampling_select;
	} rx_ctrl_type;

	typedef struct packed {
		logic [4:0] align_count;
		logic last_in_window;
		logic second_armed;
		logic receiver_active;
	} status_type;

endpackage

//--- level_sync3.sv
// Three-stage synchroniser that accepts a new level once stages two and three agree
module level_sync3 (
	input wire logic i_clk, // System clock
	input wire logic i_rst_n, // Asynchronous reset, active low
	input wire logic i_async, // Level from outside this clock domain
	output logic o_level // Filtered synchronous level
);

	logic meta_q;
	logic s2_q;
	logic s3_q;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else begin
			meta_q <= i_async;
			s2_q <= meta_q;
			s3_q <= s2_q;
		end
	end

	// Single-cycle glitch past stage two never reaches the output
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_level <= 1'b0;
		end else if (s2_q == s3_q) begin
			o_level <= s3_q;
		end
	end

endmodule

//--- ref_pulse_align.sv
// Reference pulse divider/multiframe aligner with AXI4-Lite register access
module ref_pulse_align
	import ref_pulse_align_pkg::*;
(
	input wire logic i_clk, // 25 MHz system clock
	input wire logic i_rst_n, // Asynchronous reset, active low
	input wire logic i_awvalid, // Write address valid
	output logic o_awready, // Write address ready
	input wire logic [ADDR_W-1:0] i_awaddr, // Write byte address
	input wire logic i_wvalid, // Write data valid
	output logic o_wready, // Write data ready
	input wire logic [DATA_W-1:0] i_wdata, // Write data
	input wire logic [3:0] i_wstrb, // Write byte strobes
	output logic o_bvalid, // Write response valid
	input wire logic i_bready, // Write response ready
	output logic [1:0] o_bresp, // Write response code
	input wire logic i_arvalid, // Read address valid
	output logic o_arready, // Read address ready
	input wire logic [ADDR_W-1:0] i_araddr, // Read byte address
	output logic o_rvalid, // Read data valid
	input wire logic i_rready, // Read data ready
	output logic [DATA_W-1:0] o_rdata, // Read data
	output logic [1:0] o_rresp, // Read response code
	input wire logic i_ref_pulse, // Reference pulse pin, asynchronous
	input wire logic i_synth_ref_tick, // Synthesizer reference tick
	input wire logic [SER_W-1:0] i_ser_data, // Serializer data in
	output logic [SER_W-1:0] o_ser_data, // Serializer data out
	output logic o_ref_rx_enable, // Pulse receiver enabled
	output logic o_divider_align, // Divider realign strobe
	output logic o_nco_reset, // NCO phase reset strobe
	output logic o_frame_edge, // Frame boundary strobe
	output logic o_mf_edge // Multiframe boundary strobe
);

	align_ctrl_type ctrl_q;
	mf_offset_type offset_q;
	window_type window_q;
	ser_pol_type ser_pol_q;
	rx_ctrl_type rx_ctrl_q;
	status_type status;

	logic aw_held_q;
	logic [ADDR_W-1:0] aw_addr_q;
	logic w_held_q;
	logic [DATA_W-1:0] w_data_q;
	logic [3:0] w_strb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [DATA_W-1:0] rdata_q;
	logic [1:0] rresp_q;
	logic do_write;
	logic wr_lane0;
	logic wr_ctrl;
	align_ctrl_type wr_fields;
	logic wr_mapped;
	logic [REG_W-1:0] wr_byte;
	logic [REG_W-1:0] rd_byte;
	logic rd_mapped;

	logic pulse_level;
	logic half_q;
	logic sample_en;
	logic sampled_q;
	logic pulse;
	logic second_q;
	logic second_wait;
	logic consume_next;
	logic pulse_sel;
	logic in_window;
	logic align;
	logic nco_hit;
	logic [PHASE_W-1:0] phase_q;
	logic [PHASE_W-1:0] early_dist;
	logic [PHASE_W:0] late_lim;
	logic [PHASE_W:0] early_lim;
	logic [4:0] align_count_q;
	logic last_in_window_q;

	// Register bus: write address and data taken in either order
	assign o_awready = !aw_held_q;
	assign o_wready = !w_held_q;
	assign do_write = aw_held_q && w_held_q && !bvalid_q;
	assign wr_lane0 = w_strb_q[0];
	assign wr_byte = w_data_q[REG_W-1:0];
	assign wr_fields = wr_byte;
	assign wr_ctrl = do_write && wr_lane0 && (aw_addr_q == ADDR_ALIGN_CTRL);

	always_comb begin
		case (aw_addr_q)
			ADDR_ALIGN_CTRL,
			ADDR_MF_OFFSET,
			ADDR_WINDOW,
			ADDR_SER_POL,
			ADDR_RX_CTRL,
			ADDR_STATUS: wr_mapped = 1'b1;
			default: wr_mapped = 1'b0;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			aw_held_q <= 1'b0;
			aw_addr_q <= '0;
		end else if (i_awvalid && o_awready) begin
			aw_held_q <= 1'b1;
			aw_addr_q <= i_awaddr;
		end else if (do_write) begin
			aw_held_q <= 1'b0;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			w_held_q <= 1'b0;
			w_data_q <= '0;
			w_strb_q <= '0;
		end else if (i_wvalid && o_wready) begin
			w_held_q <= 1'b1;
			w_data_q <= i_wdata;
			w_strb_q <= i_wstrb;
		end else if (do_write) begin
			w_held_q <= 1'b0;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else if (do_write) begin
			bvalid_q <= 1'b1;
			bresp_q <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (i_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	assign o_bvalid = bvalid_q;
	assign o_bresp = bresp_q;

	// Plain registers; status is read-only and ignores writes
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			offset_q <= RST_MF_OFFSET;
			window_q <= RST_WINDOW;
			ser_pol_q <= RST_SER_POL;
			rx_ctrl_q <= RST_RX_CTRL;
		end else if (do_write && wr_lane0) begin
			case (aw_addr_q)
				ADDR_MF_OFFSET: offset_q <= wr_byte;
				ADDR_WINDOW: window_q <= wr_byte;
				ADDR_SER_POL: ser_pol_q <= wr_byte;
				ADDR_RX_CTRL: rx_ctrl_q <= wr_byte;
				default: ;
			endcase
		end
	end

	// Software write wins over hardware self-clear in the same cycle
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctrl_q <= RST_ALIGN_CTRL;
		end else if (wr_ctrl) begin
			ctrl_q <= wr_byte;
		end else if (consume_next) begin
			ctrl_q.align_next_pulse_once <= 1'b0; // [RULE2]
			ctrl_q.nco_reset_next_pulse_once <= 1'b0; // [RULE5]
		end
	end

	// Read channel
	assign status.align_count = align_count_q;
	assign status.last_in_window = last_in_window_q;
	assign status.second_armed = second_q;
	assign status.receiver_active = o_ref_rx_enable;

	always_comb begin
		rd_mapped = 1'b1;
		case (i_araddr)
			ADDR_ALIGN_CTRL: rd_byte = ctrl_q;
			ADDR_MF_OFFSET: rd_byte = offset_q;
			ADDR_WINDOW: rd_byte = window_q;
			ADDR_SER_POL: rd_byte = ser_pol_q;
			ADDR_RX_CTRL: rd_byte = rx_ctrl_q;
			ADDR_STATUS: rd_byte = status;
			default: begin
				rd_byte = '0;
				rd_mapped = 1'b0;
			end
		endcase
	end

	assign o_arready = !rvalid_q;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= RESP_OKAY;
		end else if (i_arvalid && o_arready) begin
			rvalid_q <= 1'b1;
			rdata_q <= {{(DATA_W-REG_W){1'b0}}, rd_byte};
			rresp_q <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (i_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	assign o_rvalid = rvalid_q;
	assign o_rdata = rdata_q;
	assign o_rresp = rresp_q;

	// Pulse receiver and sampling
	assign o_ref_rx_enable = !rx_ctrl_q.ref_pulse_receiver_powerdown;

	level_sync3 u_pulse_sync (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_async(i_ref_pulse),
		.o_level(pulse_level)
	);

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			half_q <= 1'b0;
		end else begin
			half_q <= !half_q;
		end
	end

	always_comb begin
		if (rx_ctrl_q.ref_pulse_sampling_select) begin
			sample_en = half_q; // [RULE11]
		end else begin
			sample_en = i_synth_ref_tick; // [RULE11]
		end
	end

	// Powered-down receiver holds the sample low so no edge is seen
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sampled_q <= 1'b0;
		end else if (!o_ref_rx_enable) begin
			sampled_q <= 1'b0; // [RULE12]
		end else if (sample_en) begin
			sampled_q <= pulse_level;
		end
	end

	assign pulse = sample_en && o_ref_rx_enable && pulse_level && !sampled_q;

	// Pulse selection
	always_comb begin
		second_wait = ctrl_q.align_next_pulse_once &&
			ctrl_q.align_on_second_pulse && !second_q; // [RULE3]
		consume_next = pulse && ctrl_q.align_next_pulse_once &&
			!second_wait; // [RULE2]
		pulse_sel = pulse && (ctrl_q.align_every_pulse || consume_next); // [RULE1]
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			second_q <= 1'b0;
		end else if (wr_ctrl && wr_fields.align_next_pulse_once) begin
			second_q <= 1'b0; // [RULE13]
		end else if (consume_next) begin
			second_q <= 1'b0;
		end else if (pulse && second_wait) begin
			second_q <= 1'b1; // [RULE3]
		end
	end

	// Tolerance window around the expected position, phase zero
	always_comb begin
		early_dist = PHASE_ZERO - phase_q;
		late_lim = {{(PHASE_W-TOL_W){1'b0}}, window_q.late_tolerance, 1'b0};
		early_lim = {{(PHASE_W-TOL_W){1'b0}}, window_q.early_tolerance, 1'b0};
		in_window = ({1'b0, phase_q} <= late_lim) || // [RULE9]
			({1'b0, early_dist} <= early_lim); // [RULE8]
		align = pulse_sel && !in_window;
		nco_hit = align && (
			(ctrl_q.align_every_pulse && ctrl_q.nco_reset_every_pulse) || // [RULE4]
			(consume_next && ctrl_q.nco_reset_next_pulse_once) || // [RULE5]
			(consume_next && ctrl_q.align_on_second_pulse &&
				ctrl_q.nco_reset_on_second_pulse)); // [RULE6]
	end

	// Divider phase; a realign puts the pulse cycle at phase zero
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			phase_q <= PHASE_ZERO;
		end else if (align) begin
			phase_q <= PHASE_AFTER_ALIGN; // [RULE1]
		end else begin
			phase_q <= phase_q + PHASE_AFTER_ALIGN;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			align_count_q <= '0;
			last_in_window_q <= 1'b0;
		end else if (pulse_sel) begin
			last_in_window_q <= in_window;
			if (align) begin
				align_count_q <= align_count_q + 5'h01;
			end
		end
	end

	// Strobes and serializer data are registered
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_divider_align <= 1'b0;
			o_nco_reset <= 1'b0;
			o_frame_edge <= 1'b0;
			o_mf_edge <= 1'b0;
		end else begin
			o_divider_align <= align;
			o_nco_reset <= nco_hit;
			o_frame_edge <= phase_q[FRAME_BITS-1:0] == FRAME_START;
			o_mf_edge <= (phase_q[FRAME_BITS-1:0] == FRAME_START) &&
				(phase_q[PHASE_W-1:FRAME_BITS] ==
				offset_q.frame_offset); // [RULE7]
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_ser_data <= '0;
		end else begin
			o_ser_data <= i_ser_data ^
				{SER_W{ser_pol_q.serializer_polarity_select}}; // [RULE10]
		end
	end

endmodule

//--- ref_pulse_align_properties.sv
// Port assertions for the reference pulse aligner
module ref_pulse_align_properties
	import ref_pulse_align_pkg::*;
(
	input wire logic i_clk, // System clock
	input wire logic i_rst_n, // Reset, active low
	input wire logic o_awready, // Write address ready
	input wire logic o_wready, // Write data ready
	input wire logic o_bvalid, // Write response valid
	input wire logic i_bready, // Write response ready
	input wire logic o_arready, // Read address ready
	input wire logic o_rvalid, // Read data valid
	input wire logic i_rready, // Read data ready
	input wire logic [DATA_W-1:0] o_rdata, // Read data
	input wire logic i_ref_pulse, // Reference pulse pin
	input wire logic o_ref_rx_enable, // Receiver enabled
	input wire logic o_divider_align, // Realign strobe
	input wire logic o_nco_reset, // NCO reset strobe
	input wire logic o_frame_edge, // Frame strobe
	input wire logic o_mf_edge // Multiframe strobe
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [4:0] since_q;
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);
	// Saturates so a stale pulse can never look recent
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			since_q <= 5'h1f;
		else if (i_ref_pulse)
			since_q <= 5'h00;
		else if (since_q != 5'h1f)
			since_q <= since_q + 5'h01;
	end
	sequence frame_gap;
		!o_frame_edge [*3];
	endsequence
	sequence rx_off;
		!o_ref_rx_enable [*8];
	endsequence
	rdata_hold_a: assert property (o_rvalid && !i_rready |=>
		o_rvalid && $stable(o_rdata))
		else $error("read data changed before it was taken");
	rdata_upper_a: assert property (o_rvalid |-> o_rdata[31:8] == 24'h0)
		else $error("read data upper bits not zero");
	read_busy_a: assert property (o_rvalid |-> !o_arready)
		else $error("read address accepted while data pending");
	// Ready may return early; only the response must wait for bready
	bresp_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid)
		else $error("write response dropped before it was taken");
	nco_align_a: assert property (o_nco_reset |-> o_divider_align)
		else $error("NCO reset without realignment");
	align_cause_a: assert property (
		o_divider_align |-> since_q <= 5'h10)
		else $error("realign without a recent reference pulse");
	align_gap_a: assert property (o_divider_align |=>
		!o_divider_align [*3])
		else $error("realign strobes too close");
	rx_off_a: assert property (rx_off |-> !o_divider_align)
		else $error("realign while receiver powered down");
	frame_gap_a: assert property (o_frame_edge |=> frame_gap)
		else $error("frame strobes closer than a frame");
	mf_frame_a: assert property (o_mf_edge |-> o_frame_edge)
		else $error("multiframe strobe off a frame boundary");
endmodule
bind ref_pulse_align ref_pulse_align_properties props (.i_clk(i_clk),
	.i_rst_n(i_rst_n), .o_awready(o_awready), .o_wready(o_wready),
	.o_bvalid(o_bvalid), .i_bready(i_bready), .o_arready(o_arready),
	.o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata),
	.i_ref_pulse(i_ref_pulse),
	.o_ref_rx_enable(o_ref_rx_enable), .o_divider_align(o_divider_align),
	.o_nco_reset(o_nco_reset), .o_frame_edge(o_frame_edge),
	.o_mf_edge(o_mf_edge));

//--- ref_pulse_gen.sv
// Reference pulse source on a fixed 128-cycle multiframe grid
module ref_pulse_gen (
	input wire logic i_clk, // System clock
	input wire logic i_rst_n, // Reset, active low
	input wire logic i_arm, // Request one pulse
	input wire logic [6:0] i_phase, // Grid slot of the pulse
	output logic o_pulse, // Reference pulse pin
	output logic [6:0] o_grid // Grid position
);
	timeunit 1ns;
	timeprecision 1ns;
	logic pend_q;
	logic [6:0] slot_q;
	logic [2:0] wid_q;
	// Grid period fixed at one multiframe so a repeat at the same slot never shifts dividers
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			o_grid <= 7'h00;
		else
			o_grid <= o_grid + 7'h01;
	end
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pend_q <= 1'b0;
			slot_q <= 7'h00;
			wid_q <= 3'h0;
		end else if (i_arm) begin
			pend_q <= 1'b1;
			slot_q <= i_phase;
		end else if (pend_q && o_grid == slot_q) begin
			pend_q <= 1'b0;
			wid_q <= 3'h4;
		end else if (wid_q != 3'h0)
			wid_q <= wid_q - 3'h1;
	end
	// Low between pulses, so every pulse has a clean rise
	assign o_pulse = wid_q != 3'h0;
endmodule

//--- ref_pulse_align_bench.sv
// Register and pulse tests of the reference pulse aligner
module ref_pulse_align_bench import ref_pulse_align_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
	logic tick = 1'b0, arm = 1'b0;
	logic awr, wrdy, bv, arr, rv, pin, rxe, dal, ncr, fe, mfe;
	logic [ADDR_W-1:0] awa = '0, ara = '0;
	logic [DATA_W-1:0] wd = '0, rd;
	logic [1:0] br, rr;
	logic [SER_W-1:0] sd = 10'h2a5, so;
	logic [6:0] ph = 7'h00, grid, m0, m5;
	int errors = 0, samples_checked = 0, cycles = 0, aligns = 0, ncos = 0;
	always #20 i_clk = ~i_clk;
	ref_pulse_align DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_awvalid(awv),
		.o_awready(awr), .i_awaddr(awa), .i_wvalid(wv), .o_wready(wrdy),
		.i_wdata(wd), .i_wstrb(4'hf), .o_bvalid(bv), .i_bready(bre),
		.o_bresp(br), .i_arvalid(arv), .o_arready(arr), .i_araddr(ara),
		.o_rvalid(rv), .i_rready(rre), .o_rdata(rd), .o_rresp(rr),
		.i_ref_pulse(pin), .i_synth_ref_tick(tick), .i_ser_data(sd),
		.o_ser_data(so), .o_ref_rx_enable(rxe), .o_divider_align(dal),
		.o_nco_reset(ncr), .o_frame_edge(fe), .o_mf_edge(mfe));
	ref_pulse_gen gen (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_arm(arm),
		.i_phase(ph), .o_pulse(pin), .o_grid(grid));
	task automatic finish_test();
		$display("checked %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge i_clk) begin
		cycles++;
		if (dal === 1'b1)
			aligns++;
		if (ncr === 1'b1)
			ncos++;
		if (cycles == 40000) begin
			errors++;
			finish_test();
		end
	end
	task automatic check(input string n, input logic [31:0] s, e);
		samples_checked++;
		if (s !== e) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d,
		input logic [1:0] r);
		@(posedge i_clk);
		awv <= 1'b1;
		wv <= 1'b1;
		awa <= a;
		wd <= {24'h000000, d};
		bre <= 1'b1;
		do begin
			@(posedge i_clk);
			if (awr === 1'b1)
				awv <= 1'b0;
			if (wrdy === 1'b1)
				wv <= 1'b0;
		end while (awv && awr !== 1'b1 || wv && wrdy !== 1'b1);
		while (bv !== 1'b1)
			@(posedge i_clk);
		bre <= 1'b0;
		check("bresp", {30'h0, br}, {30'h0, r});
	endtask
	// Ready raised late so the data-hold path is exercised
	task automatic rdc(input string n, input logic [ADDR_W-1:0] a,
		input logic [7:0] d, input logic [1:0] r);
		@(posedge i_clk);
		arv <= 1'b1;
		ara <= a;
		do @(posedge i_clk); while (arr !== 1'b1);
		arv <= 1'b0;
		do @(posedge i_clk); while (rv !== 1'b1);
		rre <= 1'b1;
		@(posedge i_clk);
		rre <= 1'b0;
		check(n, rd, {24'h0, d});
		check(n, {30'h0, rr}, {30'h0, r});
	endtask
	task automatic pc(input logic [6:0] p, input int ea, en);
		int a0, n0;
		a0 = aligns;
		n0 = ncos;
		@(posedge i_clk);
		arm <= 1'b1;
		ph <= p;
		@(posedge i_clk);
		arm <= 1'b0;
		repeat (160) @(posedge i_clk);
		check("aligns", aligns - a0, ea);
		check("nco", ncos - n0, en);
	endtask
	task automatic mf(output logic [6:0] q);
		repeat (130) @(posedge i_clk);
		do @(posedge i_clk); while (mfe !== 1'b1);
		q = grid;
	endtask
	initial begin
		repeat (4) @(posedge i_clk);
		i_rst_n <= 1'b1;
		rdc("ctrl", ADDR_ALIGN_CTRL, 8'h00, RESP_OKAY);
		rdc("offset", ADDR_MF_OFFSET, 8'h00, RESP_OKAY);
		rdc("window", ADDR_WINDOW, 8'h00, RESP_OKAY);
		rdc("ser_pol", ADDR_SER_POL, 8'h1c, RESP_OKAY);
		rdc("rx_ctrl", ADDR_RX_CTRL, 8'h01, RESP_OKAY);
		rdc("unmapped", 12'h000, 8'h00, RESP_SLVERR);
		wr(12'h000, 8'h55, RESP_SLVERR);
		$display("test registers done");
		wr(ADDR_SER_POL, 8'h9c, RESP_OKAY);
		repeat (2) @(posedge i_clk);
		check("ser_inv", {22'h0, so}, {22'h0, ~sd});
		wr(ADDR_SER_POL, 8'h1c, RESP_OKAY);
		repeat (2) @(posedge i_clk);
		check("ser_pass", {22'h0, so}, {22'h0, sd});
		mf(m0);
		wr(ADDR_MF_OFFSET, 8'h05, RESP_OKAY);
		mf(m5);
		check("mf_shift", {25'h0, m5 - m0}, 32'h14);
		$display("test polarity and offset done");
		wr(ADDR_ALIGN_CTRL, 8'h11, RESP_OKAY);
		pc(7'h40, 1, 1);
		pc(7'h40, 0, 0);
		pc(7'h60, 1, 1);
		wr(ADDR_ALIGN_CTRL, 8'h22, RESP_OKAY);
		pc(7'h20, 1, 1);
		rdc("ctrl_once", ADDR_ALIGN_CTRL, 8'h00, RESP_OKAY);
		pc(7'h40, 0, 0);
		wr(ADDR_ALIGN_CTRL, 8'h46, RESP_OKAY);
		pc(7'h10, 0, 0);
		pc(7'h30, 1, 1);
		rdc("ctrl_second", ADDR_ALIGN_CTRL, 8'h44, RESP_OKAY);
		wr(ADDR_ALIGN_CTRL, 8'h46, RESP_OKAY);
		pc(7'h50, 0, 0);
		wr(ADDR_ALIGN_CTRL, 8'h46, RESP_OKAY);
		pc(7'h70, 0, 0);
		pc(7'h14, 1, 1);
		$display("test alignment modes done");
		wr(ADDR_ALIGN_CTRL, 8'h01, RESP_OKAY);
		wr(ADDR_WINDOW, 8'h22, RESP_OKAY);
		pc(7'h18, 0, 0);
		pc(7'h1a, 1, 0);
		pc(7'h16, 0, 0);
		pc(7'h14, 1, 0);
		$display("test window done");
		wr(ADDR_RX_CTRL, 8'h09, RESP_OKAY);
		check("rx_off", {31'h0, rxe}, 32'h0);
		pc(7'h5a, 0, 0);
		wr(ADDR_RX_CTRL, 8'h00, RESP_OKAY);
		check("rx_on", {31'h0, rxe}, 32'h1);
		pc(7'h5a, 0, 0);
		tick <= 1'b1;
		pc(7'h5a, 1, 0);
		// Eight realigns so far, last one outside the window, receiver on
		rdc("status", ADDR_STATUS, 8'h41, RESP_OKAY);
		$display("test receiver done");
		finish_test();
	end
endmodule
